/* File: logic/mcr_addr_mux.sv */
// Row and column address multiplexer for the memory address lines
`default_nettype none
module mcr_addr_mux
	import mcr_pkg::*;
(
	input  wire logic        clk,          // System clock
	input  wire logic        resetn,       // Async reset, active low
	mcr_cfg_if.mux           cfg,          // Configuration fields
	input  wire logic [31:0] logical_addr, // Logical bit address
	input  wire logic        row_phase,    // High at row-address time
	input  wire logic        column_shift_select, // Shifted column
	output logic      [12:0] multiplexed_address_lines // Address pins
);
	logic [12:0] next_lines; // Combinational line value
	logic        sel;        // 16-bit word select

	// Select the logical bits for each address line
	always_comb begin
		sel = logical_addr[MCR_WORD_SEL];
		next_lines = logical_addr[MCR_COL_BASE +: MCR_LINES];
		if (row_phase) begin
			// Window moves up one bit per map step
			next_lines = logical_addr[(MCR_ROW_BASE +
				32'(cfg.row_column_map_mode)) +: MCR_LINES];
		end else if (column_shift_select) begin
			// Middle bits shifted, lines 0-1 by map, 11-12 word select, line 12 by map in mode 3
			next_lines[10:2] = logical_addr[13:5];
			next_lines[11] = sel;
			next_lines[12] = sel;
			case (cfg.row_column_map_mode)
				2'h0: begin
					next_lines[0] = logical_addr[23];
					next_lines[1] = logical_addr[22];
				end
				2'h1: begin
					next_lines[0] = logical_addr[26];
					next_lines[1] = logical_addr[14];
				end
				2'h2: begin
					next_lines[0] = logical_addr[15];
					next_lines[1] = logical_addr[14];
				end
				default: begin
					next_lines[0] = logical_addr[28];
					next_lines[1] = logical_addr[14];
					next_lines[12] = logical_addr[16];
				end
			endcase
		end
	end

	// Registered address pins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			multiplexed_address_lines <= 13'h0000;
		end else begin
			multiplexed_address_lines <= next_lines;
		end
	end
endmodule
`default_nettype wire

/* File: logic/mcr_config_top.sv */
// Memory configuration register, boot load, refresh and slot arbiter
`default_nettype none
module mcr_config_top
	import mcr_pkg::*;
(
	input  wire logic        clk,            // System clock
	input  wire logic        resetn,         // Async reset, active low
	input  wire logic        host_present,   // Host-present strap
	input  wire logic        host_reset_req, // Software reset pulse
	input  wire logic        cfg_write,      // Config write strobe
	input  wire logic [15:0] cfg_wdata,      // Config write data
	output logic      [15:0] cfg_rdata,      // Config read value
	output logic             vec_read_req,   // Reset vector read
	output logic      [31:0] vec_read_addr,  // Reset vector address
	input  wire logic        vec_read_ack,   // Vector data valid
	input  wire logic [31:0] vec_read_data,  // Vector data
	output logic             fetch_enable,   // Instruction fetch ok
	output logic      [31:0] fetch_start,    // Fetch start address
	input  wire logic        plane_mask_write, // Plane mask strobe
	input  wire logic [31:0] plane_mask_data,  // Plane mask value
	output logic      [31:0] write_mask_value, // Inverted mask
	output logic             masked_write_mode, // Use masked cycles
	input  wire logic        vram_block_fill_op, // Block fill issue
	input  wire logic        vram_block_copy_op, // Block copy issue
	output logic             vram_block_go,  // Block op proceeds
	input  wire logic        mem_slot_free,  // Memory slot open
	input  wire logic        cpu_mem_req,    // Processor memory req
	output logic      [1:0]  slot_grant,     // Slot owner, one cycle
	input  wire logic        refresh_complete, // Refresh finished
	input  wire logic        refresh_retried,  // Refresh retried
	input  wire logic        mask_load_done,   // Mask load finished
	output logic             mask_load_pending, // Mask load waiting
	output logic      [3:0]  refresh_pending,   // Pending count
	output logic             byte_order_select, // Big endian
	input  wire logic [31:0] logical_addr,      // Logical address
	input  wire logic        row_phase,         // Row-address time
	input  wire logic        column_shift_select, // Column shift
	output logic      [12:0] multiplexed_address_lines // Addr pins
);
	// ----------------------------------------------------------------
	// Internal state
	// ----------------------------------------------------------------
	mcr_cfg_if      cfg_bus ();     // Link to submodules
	mcr_boot_type   boot;           // Boot sequence state
	mcr_slot_type   next_slot;      // Slot decision
	logic    [15:0] config_reg;     // Configuration register
	logic    [15:0] next_config;    // Write merge result
	logic           lock;           // Low byte lock bit
	logic           mask_en;        // VRAM mask support
	logic    [31:0] plane_mask;     // Copy of plane mask
	logic           urgent;         // Twelve or more pending
	logic           over_cpu;       // Four or more pending

	assign lock    = config_reg[MCR_BIT_LOCK];
	assign mask_en = config_reg[MCR_BIT_VRAM_MASK];
	assign urgent  = cfg_bus.pending >= MCR_PEND_URGENT;
	assign over_cpu = cfg_bus.pending >= MCR_PEND_OVER_CPU;
	assign cfg_bus.row_column_map_mode =
		config_reg[MCR_MAP_LSB +: 2];
	assign cfg_bus.refresh_interval_select =
		config_reg[MCR_RR_LSB +: 3];
	assign cfg_bus.refresh_done  = refresh_complete && !refresh_retried;
	assign cfg_bus.refresh_retry = refresh_retried;

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	mcr_addr_mux u_mux (
		.clk                       (clk),
		.resetn                    (resetn),
		.cfg                       (cfg_bus),
		.logical_addr              (logical_addr),
		.row_phase                 (row_phase),
		.column_shift_select       (column_shift_select),
		.multiplexed_address_lines (multiplexed_address_lines)
	);

	mcr_refresh u_refresh (
		.clk    (clk),
		.resetn (resetn),
		.cfg    (cfg_bus)
	);

	// ----------------------------------------------------------------
	// Configuration register
	// ----------------------------------------------------------------
	// Merge a software write with the lock
	always_comb begin
		next_config = cfg_wdata & MCR_CFG_WMASK; // Bit 4 unused
		if (lock) begin
			next_config[7:0] = config_reg[7:0];
		end
	end

	// Register update: reset, vector load, software write
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			config_reg <= MCR_CFG_RESET;
		end else if (host_reset_req) begin
			config_reg <= MCR_CFG_RESET; // Clears the lock
		end else if (boot == MCR_BOOT_VECTOR && vec_read_ack) begin
			config_reg[3:0] <= vec_read_data[3:0] & MCR_VEC_BITS;
		end else if (cfg_write && boot == MCR_BOOT_RUN) begin
			config_reg <= next_config; // Lock never cleared here
		end
	end

	// Read-back copy
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_rdata <= MCR_CFG_RESET;
		end else begin
			cfg_rdata <= config_reg;
		end
	end

	// Endian select output
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			byte_order_select <= 1'b0;
		end else begin
			byte_order_select <= config_reg[MCR_BIT_BYTE_ORDER];
		end
	end

	// ----------------------------------------------------------------
	// Boot sequence
	// ----------------------------------------------------------------
	// Strap sampled after release; host mode skips the vector
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			boot          <= MCR_BOOT_SAMPLE;
			vec_read_req  <= 1'b0;
			vec_read_addr <= 32'h00000000;
			fetch_enable  <= 1'b0;
			fetch_start   <= 32'h00000000;
		end else if (host_reset_req) begin
			boot          <= MCR_BOOT_SAMPLE;
			vec_read_req  <= 1'b0;
			fetch_enable  <= 1'b0;
		end else begin
			case (boot)
				MCR_BOOT_SAMPLE: begin
					if (host_present) begin
						boot         <= MCR_BOOT_RUN;
						fetch_enable <= 1'b1;
					end else begin
						boot          <= MCR_BOOT_VECTOR;
						vec_read_req  <= 1'b1;
						vec_read_addr <= MCR_VEC_ADDR;
					end
				end
				MCR_BOOT_VECTOR: begin
					if (vec_read_ack) begin
						boot         <= MCR_BOOT_RUN;
						vec_read_req <= 1'b0;
						fetch_enable <= 1'b1; // Same edge as copy
						// Word aligned start
						fetch_start  <= {vec_read_data[31:4], 4'h0};
					end
				end
				MCR_BOOT_RUN: begin
					vec_read_req <= 1'b0;
				end
				default: begin
					boot <= MCR_BOOT_SAMPLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// VRAM write mask
	// ----------------------------------------------------------------
	// Plane mask copy and inverted load value
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			plane_mask       <= 32'h00000000;
			write_mask_value <= 32'hFFFFFFFF;
		end else if (plane_mask_write) begin
			plane_mask       <= plane_mask_data;
			write_mask_value <= ~plane_mask_data;
		end
	end

	// Load request: a new write wins over completion
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mask_load_pending <= 1'b0;
		end else if (plane_mask_write && mask_en) begin
			mask_load_pending <= 1'b1;
		end else if (mask_load_done) begin
			mask_load_pending <= 1'b0;
		end
	end

	// Masked cycles and block ops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			masked_write_mode <= 1'b0;
			vram_block_go     <= 1'b0;
		end else begin
			masked_write_mode <= mask_en && (plane_mask != 32'h00000000);
			vram_block_go <= vram_block_fill_op || vram_block_copy_op;
		end
	end

	// ----------------------------------------------------------------
	// Memory slot arbiter
	// ----------------------------------------------------------------
	// Priority: urgent refresh, mask load, refresh over cpu, cpu
	always_comb begin
		next_slot = MCR_SLOT_NONE;
		if (mem_slot_free) begin
			if (urgent) begin
				next_slot = MCR_SLOT_REFRESH;
			end else if (mask_load_pending && !mask_load_done) begin
				// Finished load is not issued a second time
				next_slot = MCR_SLOT_MASK;
			end else if (over_cpu) begin
				next_slot = MCR_SLOT_REFRESH;
			end else if (cpu_mem_req) begin
				next_slot = MCR_SLOT_CPU;
			end else if (cfg_bus.pending != 4'h0) begin
				next_slot = MCR_SLOT_REFRESH;
			end
		end
	end

	// Registered grant, processor grant held off while mask load waits
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			slot_grant <= MCR_SLOT_NONE;
		end else if (next_slot == MCR_SLOT_CPU && mask_load_pending) begin
			slot_grant <= MCR_SLOT_NONE;
		end else begin
			slot_grant <= next_slot;
		end
	end

	// Pending count out
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			refresh_pending <= 4'h0;
		end else begin
			refresh_pending <= cfg_bus.pending;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_locked_write;
		lock && cfg_write && boot == MCR_BOOT_RUN && !host_reset_req;
	endsequence
	sequence s_mask_trigger;
		plane_mask_write && mask_en;
	endsequence

	a_lock_low_byte: assert property (@(posedge clk) disable iff (!resetn)
		s_locked_write |=> $stable(config_reg[7:0]))
		else $error("locked low byte changed");
	a_lock_upper_byte: assert property (@(posedge clk)
		disable iff (!resetn) s_locked_write |=>
		config_reg[15:8] == ($past(cfg_wdata[15:8]) & 8'h1D))
		else $error("upper byte not written under lock");
	a_lock_sticky: assert property (@(posedge clk) disable iff (!resetn)
		lock && !host_reset_req |=> lock)
		else $error("lock cleared without reset");
	a_vector_copy: assert property (@(posedge clk) disable iff (!resetn)
		boot == MCR_BOOT_VECTOR && vec_read_ack && !host_reset_req
		|=> config_reg[3:0] == $past(vec_read_data[3:0])
		&& fetch_enable && fetch_start[3:0] == 4'h0)
		else $error("vector bits not copied before fetch");
	a_no_fetch_early: assert property (@(posedge clk)
		disable iff (!resetn) boot != MCR_BOOT_RUN |-> !fetch_enable)
		else $error("fetch enabled before boot done");
	a_mask_request: assert property (@(posedge clk) disable iff (!resetn)
		s_mask_trigger |=> mask_load_pending
		&& write_mask_value == ~$past(plane_mask_data))
		else $error("mask load not requested");
	a_cpu_held: assert property (@(posedge clk) disable iff (!resetn)
		mask_load_pending |=> slot_grant != MCR_SLOT_CPU)
		else $error("cpu granted during mask load");
	a_urgent_refresh: assert property (@(posedge clk)
		disable iff (!resetn) mem_slot_free && urgent
		|=> slot_grant == MCR_SLOT_REFRESH)
		else $error("urgent refresh not granted");
	a_refresh_over_cpu: assert property (@(posedge clk)
		disable iff (!resetn) mem_slot_free && over_cpu
		&& !mask_load_pending |=> slot_grant == MCR_SLOT_REFRESH)
		else $error("cpu beat pending refreshes");
	a_retry_keeps: assert property (@(posedge clk) disable iff (!resetn)
		refresh_retried && cfg_bus.pending != MCR_PEND_MAX
		|=> cfg_bus.pending >= $past(cfg_bus.pending))
		else $error("retry decremented pending");
	a_block_ungated: assert property (@(posedge clk)
		disable iff (!resetn) vram_block_fill_op || vram_block_copy_op
		|=> vram_block_go)
		else $error("block op gated");
endmodule
`default_nettype wire

/* File: logic/mcr_refresh.sv */
// Refresh interval timer and pending-refresh counter
`default_nettype none
module mcr_refresh
	import mcr_pkg::*;
(
	input  wire logic clk,    // System clock
	input  wire logic resetn, // Async reset, active low
	mcr_cfg_if.refr   cfg     // Interval code, status
);
	logic [7:0] interval;  // Machine-state counter
	logic [7:0] last;      // Final count of the period
	logic       tick;      // Refresh request scheduled
	logic       off;       // Refresh disabled
	logic [3:0] pend;      // Pending refreshes

	assign cfg.pending = pend;

	// Period is 8 shifted left by the code
	always_comb begin
		off  = (cfg.refresh_interval_select == MCR_RR_OFF) ||
			(cfg.refresh_interval_select == MCR_RR_UNDEF);
		last = 8'((9'h001 << (MCR_RR_BASE_LOG2 +
			32'(cfg.refresh_interval_select))) - 9'h001);
		tick = !off && (interval >= last);
	end

	// Interval counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			interval <= 8'h00;
		end else if (off || tick) begin
			interval <= 8'h00;
		end else begin
			interval <= interval + 8'h01;
		end
	end

	// Pending count: up on tick, down on done, not on retry
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pend <= 4'h0;
		end else if (tick && !cfg.refresh_done) begin
			// Overflow drops all sixteen
			pend <= (pend == MCR_PEND_MAX) ? 4'h0 : pend + 4'h1;
		end else if (!tick && cfg.refresh_done && !cfg.refresh_retry &&
			pend != 4'h0) begin
			pend <= pend - 4'h1;
		end
	end
endmodule
`default_nettype wire

/* File: shared/mcr_cfg_if.sv */
// Configuration fields and refresh status shared between submodules
`default_nettype none
interface mcr_cfg_if;
	logic       [1:0] row_column_map_mode;     // Address map field
	logic       [2:0] refresh_interval_select; // Refresh period code
	logic       [3:0] pending;                 // Pending refreshes
	logic             refresh_done;            // Refresh cycle performed
	logic             refresh_retry;           // Refresh ended by retry
	modport ctl  (output row_column_map_mode, refresh_interval_select,
		refresh_done, refresh_retry, input pending);
	modport mux  (input row_column_map_mode);
	modport refr (input refresh_interval_select, refresh_done,
		refresh_retry, output pending);
endinterface
`default_nettype wire

/* File: shared/mcr_pkg.sv */
// Constants and types for the memory configuration and refresh block
`default_nettype none
package mcr_pkg;
	// ----------------------------------------------------------------
	// Configuration register layout
	// ----------------------------------------------------------------
	localparam int unsigned       MCR_BIT_BYTE_ORDER = 0;
	localparam int unsigned       MCR_MAP_LSB        = 1;
	localparam int unsigned       MCR_BIT_LOCK       = 3;
	localparam int unsigned       MCR_BIT_VRAM_MASK  = 8;
	localparam int unsigned       MCR_RR_LSB         = 10;
	localparam logic [15:0]       MCR_CFG_RESET      = 16'h0000;
	localparam logic [15:0]       MCR_CFG_WMASK      = 16'h1D0F;
	localparam logic [3:0]        MCR_VEC_BITS       = 4'hF;
	// Fixed address of the reset vector
	localparam logic [31:0]       MCR_VEC_ADDR       = 32'hFFFFFFE0;
	// ----------------------------------------------------------------
	// Refresh scheduling
	// ----------------------------------------------------------------
	localparam logic [3:0]        MCR_PEND_MAX       = 4'hF;
	localparam logic [3:0]        MCR_PEND_URGENT    = 4'hC;
	localparam logic [3:0]        MCR_PEND_OVER_CPU  = 4'h4;
	localparam logic [2:0]        MCR_RR_UNDEF       = 3'h6;
	localparam logic [2:0]        MCR_RR_OFF         = 3'h7;
	localparam int unsigned       MCR_RR_BASE_LOG2   = 3;
	// ----------------------------------------------------------------
	// Address multiplexing
	// ----------------------------------------------------------------
	localparam int unsigned       MCR_ROW_BASE       = 12;
	localparam int unsigned       MCR_COL_BASE       = 4;
	localparam int unsigned       MCR_WORD_SEL       = 4;
	localparam int unsigned       MCR_LINES          = 13;
	// Boot sequence states
	typedef enum logic [1:0] {
		MCR_BOOT_SAMPLE,
		MCR_BOOT_VECTOR,
		MCR_BOOT_RUN
	} mcr_boot_type;
	// Memory slot owner
	typedef enum logic [1:0] {
		MCR_SLOT_NONE,
		MCR_SLOT_REFRESH,
		MCR_SLOT_MASK,
		MCR_SLOT_CPU
	} mcr_slot_type;
endpackage
`default_nettype wire

/* File: tb/mcr_mem_model.sv */
// Memory-side model: reset vector, refresh and mask-load cycles
`default_nettype none
module mcr_mem_model
	import mcr_pkg::*;
(
	input  wire logic        clk,              // System clock
	input  wire logic        resetn,           // Async reset, active low
	input  wire logic        retry_mode,       // Retry every refresh
	input  wire logic        slow,             // Long memory cycles
	input  wire logic [31:0] vec_value,        // Reset vector content
	input  wire logic        vec_read_req,     // Vector wanted
	input  wire logic [31:0] vec_read_addr,    // Vector address
	input  wire logic [1:0]  slot_grant,       // Slot owner
	output logic             vec_read_ack,     // Vector valid
	output logic      [31:0] vec_read_data,    // Vector data
	output logic             mem_slot_free,    // Slot open
	output logic             refresh_complete, // Refresh ended
	output logic             refresh_retried,  // Refresh retried
	output logic             mask_load_done    // Mask load ended
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] busy; // Cycles left in the running cycle
	logic [1:0] kind; // Owner of the running cycle
	// Slot closes as soon as a grant shows, before it is latched
	assign mem_slot_free = (busy == 4'h0) && (slot_grant == 2'h0);
	// ----------------------------------------
	// Cycle engine
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busy <= 4'h0;
			kind <= 2'h0;
			vec_read_ack <= 1'b0;
			vec_read_data <= 32'h0;
			refresh_complete <= 1'b0;
			refresh_retried <= 1'b0;
			mask_load_done <= 1'b0;
		end else begin
			refresh_complete <= 1'b0;
			refresh_retried <= 1'b0;
			mask_load_done <= 1'b0;
			vec_read_ack <= 1'b0;
			// Released data bus keeps toggling
			vec_read_data <= ~vec_read_data;
			if (vec_read_req && !vec_read_ack &&
				vec_read_addr === MCR_VEC_ADDR) begin
				vec_read_ack <= 1'b1;
				vec_read_data <= vec_value;
			end
			if (busy == 4'h0 && slot_grant != 2'h0) begin
				kind <= slot_grant;
				busy <= slow ? 4'h4 : 4'h1;
			end else if (busy != 4'h0) begin
				busy <= busy - 4'h1;
				if (busy == 4'h1 && kind == 2'h1) begin
					refresh_complete <= 1'b1;
					refresh_retried <= retry_mode;
				end
				if (busy == 4'h1 && kind == 2'h2) begin
					mask_load_done <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/memory_config_refresh_control_test.sv */
// Self-checking bench for the configuration and refresh block
`default_nettype none
module memory_config_refresh_control_test
	import mcr_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, resetn, host_present, host_reset_req, cfg_write;
	logic        plane_mask_write, vram_block_fill_op, vram_block_copy_op;
	logic        mem_slot_free, cpu_mem_req, refresh_complete, slow;
	logic        refresh_retried, mask_load_done, row_phase, retry_mode;
	logic        column_shift_select, vec_read_req, vec_read_ack, mlp_d;
	logic        fetch_enable, masked_write_mode, vram_block_go;
	logic        mask_load_pending, byte_order_select;
	logic [15:0] cfg_wdata, cfg_rdata, cfg_m;
	logic [31:0] vec_read_addr, vec_read_data, fetch_start, a, vec_value;
	logic [31:0] plane_mask_data, write_mask_value, logical_addr;
	logic [1:0]  slot_grant;
	logic [3:0]  refresh_pending;
	logic [12:0] multiplexed_address_lines;
	int          n_mismatch, compares, seed, cyc, i, k, n;
	mcr_config_top uut (.*);
	mcr_mem_model mem (.*);
	// ----------------------------------------
	// Clock, timeout and checking tasks
	// ----------------------------------------
	initial clk = 1'b0;
	always #5 clk = ~clk;
	task automatic check_value(input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task end_of_test;
		if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 10000) begin
			n_mismatch++;
			$display("BAD %0t run too long", $time);
			end_of_test();
		end
		// No processor grant while a mask load waits
		if (mlp_d && mask_load_pending) check_value(slot_grant == 2'h3, 1'b0);
		mlp_d <= mask_load_pending;
	end
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
	endtask
	task automatic wait_sig(ref logic s, input logic v, input int lim);
		for (int j = 0; j < lim; j++) begin
			@(posedge clk);
			#1;
			if (s === v) return;
		end
		n_mismatch++;
		$display("BAD %0t no handshake", $time);
	endtask
	// Configuration write; expected value follows lock and field mask
	task automatic wr(input logic [15:0] d);
		@(posedge clk);
		cfg_write <= 1'b1;
		cfg_wdata <= d;
		@(posedge clk);
		cfg_write <= 1'b0;
		cfg_m = (cfg_m[3] ? {d[15:8], cfg_m[7:0]} : d) & MCR_CFG_WMASK;
		tick(2);
		#1;
		check_value(cfg_rdata, cfg_m);
	endtask
	// Cycles until the pending count next changes, 600 at most
	task automatic gap(output int c);
		logic [3:0] p;
		p = refresh_pending;
		c = 0;
		while (refresh_pending === p && c < 600) begin
			@(posedge clk);
			#1;
			c++;
		end
	endtask
	// Shifted column address lines per map setting
	function automatic logic [12:0] col_exp(logic [1:0] m, logic [31:0] x);
		logic [12:0] e;
		e[10:2] = x[13:5];
		e[1] = (m == 2'h0) ? x[22] : x[14];
		e[0] = (m == 2'h0) ? x[23] : (m == 2'h1) ? x[26] :
			(m == 2'h2) ? x[15] : x[28];
		e[11] = x[MCR_WORD_SEL];
		e[12] = (m == 2'h3) ? x[16] : x[MCR_WORD_SEL];
		return e;
	endfunction
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 9;
		{resetn, host_present, host_reset_req, cfg_write} = '0;
		{plane_mask_write, vram_block_fill_op, vram_block_copy_op} = '0;
		{cpu_mem_req, row_phase, column_shift_select, retry_mode} = '0;
		{cfg_wdata, plane_mask_data, logical_addr, slow, mlp_d} = '0;
		vec_value = $random(seed) | 32'h8;
		cfg_m = 16'h0000;
		tick(6);
		resetn <= 1'b1;
		// Boot reads the vector, lock bit set by it
		wait_sig(vec_read_req, 1'b1, 20);
		check_value(vec_read_addr, MCR_VEC_ADDR);
		wait_sig(fetch_enable, 1'b1, 20);
		tick(1);
		#1;
		check_value(cfg_rdata, {12'h0, vec_value[3:0]});
		check_value(fetch_start, {vec_value[31:4], 4'h0});
		cfg_m = {12'h0, vec_value[3:0]};
		a = $random(seed);
		wr(a[15:0]);
		wr(16'h0000);
		// Software reset in host mode clears the lock
		@(posedge clk);
		host_present <= 1'b1;
		host_reset_req <= 1'b1;
		@(posedge clk);
		host_reset_req <= 1'b0;
		cfg_m = 16'h0000;
		tick(3);
		#1;
		check_value(cfg_rdata, 16'h0000);
		check_value(fetch_enable, 1'b1);
		// Host sets order and map first, bit 4 set too
		for (k = 0; k < 4; k++) begin
			wr(16'h0010 | 16'(k << 1) | 16'(k[0]));
			check_value(byte_order_select, k[0]);
			for (i = 0; i < 6; i++) begin
				@(posedge clk);
				logical_addr <= $random(seed);
				row_phase <= (i % 3 == 0);
				column_shift_select <= (i % 3 == 1);
				@(posedge clk);
				#1;
				if (i % 3 == 0) check_value(multiplexed_address_lines,
					logical_addr[MCR_ROW_BASE + k +: 13]);
				if (i % 3 == 1) check_value(multiplexed_address_lines,
					col_exp(k[1:0], logical_addr));
				if (i % 3 == 2) check_value(multiplexed_address_lines,
					logical_addr[16:4]);
			end
		end
		// Plane mask writes with mask support on, processor waiting
		wr(16'h0100);
		for (k = 0; k < 2; k++) begin
			a = k ? 32'h0 : ($random(seed) | 32'h1);
			@(posedge clk);
			cpu_mem_req <= 1'b1;
			plane_mask_write <= 1'b1;
			plane_mask_data <= a;
			@(posedge clk);
			plane_mask_write <= 1'b0;
			tick(1);
			#1;
			check_value(write_mask_value, ~a);
			check_value(masked_write_mode, k == 0);
			wait_sig(mask_load_pending, 1'b0, 40);
		end
		// Block operations proceed with mask support off
		wr(16'h0000);
		for (k = 0; k < 2; k++) begin
			@(posedge clk);
			vram_block_fill_op <= (k == 0);
			vram_block_copy_op <= (k == 1);
			@(posedge clk);
			vram_block_fill_op <= 1'b0;
			vram_block_copy_op <= 1'b0;
			#1;
			check_value(vram_block_go, 1'b1);
		end
		// Refresh period per code; retries keep the count climbing
		retry_mode <= 1'b1;
		for (k = 0; k < 6; k++) begin
			wr(16'(k << MCR_RR_LSB));
			gap(n);
			gap(n);
			check_value(n, 8 << k);
		end
		wr(16'h1C00);
		gap(n);
		check_value(n, 600);
		// Overflow of the pending count, then drain by slow cycles
		wr(16'h0000);
		for (i = 0; i < 200 && refresh_pending !== 4'hF; i++) tick(1);
		#1;
		gap(n);
		check_value(refresh_pending, 4'h0);
		for (i = 0; i < 200 && refresh_pending < 4'hC; i++) tick(1);
		retry_mode <= 1'b0;
		slow <= 1'b1;
		// Processor idle, else it keeps the last three refreshes out
		cpu_mem_req <= 1'b0;
		wr(16'h1C00);
		for (i = 0; i < 300 && refresh_pending !== 4'h0; i++) tick(1);
		#1;
		check_value(refresh_pending, 4'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
